// *** ibs_map.svh ***
/*
 * Constants of the boot strap and two-wire block: strap window, serial clock
 * timing and default address bits. Assumes the clk_sys period given below.
 */
`ifndef IBS_MAP_SVH
`define IBS_MAP_SVH

// --------------------
// Strap sampling
// --------------------
`define IBS_STRAP_HOLD_CYCLES 4'd10
`define IBS_EEP_LOW_DEFAULT   2'h0

// --------------------
// Serial clock timing
// --------------------
`define IBS_CLK_PERIOD_NS     40
`define IBS_SCL_MAX_KHZ       100
`define IBS_SCL_MIN_PERIOD_NS (1000000 / `IBS_SCL_MAX_KHZ)
`define IBS_QTR_CYCLES        ((`IBS_SCL_MIN_PERIOD_NS + 4 * `IBS_CLK_PERIOD_NS - 1) / (4 * `IBS_CLK_PERIOD_NS))

`endif

// *** ibs_pkg.sv ***
/*
 * Types of the boot strap and two-wire block: strap group, sequencer states
 * and the state records of both clock domains. Assumes nothing else.
 */
package ibs_pkg;

   typedef struct packed {
      logic       eep_sel;
      logic [1:0] own_low;
      logic       multi_byte;
      logic       load_inhibit;
   } ibs_strap_t;

   typedef enum logic [2:0] {M_WAIT, M_START, M_TX, M_RX, M_STOP, M_DONE} ibs_mst_st_t;
   typedef enum logic [2:0] {S_DEVW, S_AHI, S_ALO, S_DEVR, S_RD} ibs_step_t;
   typedef enum logic [2:0] {L_IDLE, L_ADDR, L_AACK, L_WDATA, L_WACK, L_RDATA, L_RACK} ibs_slv_st_t;

   typedef struct packed {
      ibs_strap_t  strap_s1;
      ibs_strap_t  strap_s2;
      logic        scl_s1;
      logic        scl_s2;
      logic        sda_s1;
      logic        sda_s2;
      logic [3:0]  win_cnt;
      logic        straps_valid;
      ibs_strap_t  cap;
      logic [1:0]  own_low;
      logic [1:0]  eep_low;
      logic        own_tog;
      ibs_mst_st_t st;
      ibs_step_t   step;
      logic [6:0]  tmr;
      logic [1:0]  ph;
      logic [3:0]  bitn;
      logic [7:0]  sh;
      logic [7:0]  cnt;
      logic        scl_low;
      logic        sda_low;
      logic        nack;
      logic        busy;
      logic        done;
      logic        err;
      logic        valid;
      logic [7:0]  data;
   } ibs_sys_t;

   typedef struct packed {
      logic        scl_s1;
      logic        scl_s2;
      logic        sda_s1;
      logic        sda_s2;
      logic        scl_d;
      logic        sda_d;
      logic        tog_s1;
      logic        tog_s2;
      logic        tog_s3;
      logic        mscl_s1;
      logic        mscl_s2;
      logic        msda_s1;
      logic        msda_s2;
      logic [1:0]  own_low;
      logic        addr_ok;
      ibs_slv_st_t st;
      logic [3:0]  cnt;
      logic [7:0]  sh;
      logic        rw;
      logic        nack;
      logic        drive;
      logic        scl_oe;
      logic        sda_oe;
      logic        pin_o;
      logic [7:0]  wr_data;
      logic        wr_valid;
      logic        rd_load;
   } ibs_link_t;

endpackage : ibs_pkg

// *** ibs_boot_strap.sv ***
/*
 * Strap capture, boot loader master and two-wire slave of the device.
 * Assumes an external pull-up on both serial lines and a free-running clk_link.
 */
// Function
// - Own serial clock runs no faster than 100 kHz; clock line driven and observed.
// - Data line is open drain: only pulled low or released, released reads one.
// - Load-inhibit strap high skips the boot load; low performs it.
// - After the sampling window later strap changes are ignored.
// - Slave access works whatever the load-inhibit strap level.
// - Address-width strap high sends two address bytes, low sends one.
// - Two address straps form the low two bits of the own slave address.
// - Software may replace the own address low bits; slave then answers that.
// - Select strap reuses address straps for memory address low bits, else 00.
`timescale 1ns/1ps
`default_nettype none
`include "ibs_map.svh"

module ibs_boot_strap #(
   parameter logic [4:0]  OWN_ADDR_HI = 5'h0B,  // Arbitrary value.
   parameter logic [4:0]  EEP_ADDR_HI = 5'h14,
   parameter logic [15:0] LOAD_ADDR   = 16'h0000,
   parameter int          LOAD_BYTES  = 4
) (
   input  wire logic                clk_sys,
   input  wire logic                clk_link,
   input  wire logic                rst,
   input  wire ibs_pkg::ibs_strap_t straps,
   input  wire logic                sw_own_wr,
   input  wire logic [1:0]          sw_own_low,
   input  wire logic                sw_eep_wr,
   input  wire logic [1:0]          sw_eep_low,
   input  wire logic                serial_bus_clock_i,
   output logic                     serial_bus_clock_o,
   output logic                     serial_bus_clock_oe,
   input  wire logic                serial_bus_data_pin_i,
   output logic                     serial_bus_data_pin_o,
   output logic                     serial_bus_data_pin_oe,
   output logic                     straps_valid,
   output ibs_pkg::ibs_strap_t      straps_captured,
   output logic [1:0]               own_addr_low,
   output logic [1:0]               eep_addr_low,
   output logic                     load_busy,
   output logic                     load_done,
   output logic                     load_error,
   output logic [7:0]               load_data,
   output logic                     load_valid,
   input  wire logic [7:0]          slv_rd_data,
   output logic                     slv_rd_load,
   output logic [7:0]               slv_wr_data,
   output logic                     slv_wr_valid
);

   // --------------------
   // System clock domain: straps, configuration and boot loader
   // --------------------
   ibs_pkg::ibs_sys_t s_reg;
   ibs_pkg::ibs_sys_t s_next;
   logic              tick;
   logic              go;

   always_comb begin
      s_next          = s_reg;
      s_next.strap_s1 = straps;
      s_next.strap_s2 = s_reg.strap_s1;
      s_next.scl_s1   = serial_bus_clock_i;
      s_next.scl_s2   = s_reg.scl_s1;
      s_next.sda_s1   = serial_bus_data_pin_i;
      s_next.sda_s2   = s_reg.sda_s1;
      s_next.valid    = 1'b0;
      // Straps are read once at the end of the hold window, then never again.
      if (!s_reg.straps_valid) begin
         s_next.win_cnt = s_reg.win_cnt + 4'h1;
         if (s_reg.win_cnt == `IBS_STRAP_HOLD_CYCLES - 4'h1) begin
            s_next.straps_valid = 1'b1;
            s_next.cap          = s_reg.strap_s2;
            s_next.own_low      = s_reg.strap_s2.own_low;
            s_next.eep_low      = s_reg.strap_s2.eep_sel ? s_reg.strap_s2.own_low
                                                         : `IBS_EEP_LOW_DEFAULT;
            s_next.own_tog      = ~s_reg.own_tog;
         end
      end else begin
         if (sw_own_wr) begin
            s_next.own_low = sw_own_low;
            s_next.own_tog = ~s_reg.own_tog;
         end
         if (sw_eep_wr) begin
            s_next.eep_low = sw_eep_low;
         end
      end
      // A quarter of the serial period elapses per tick; a slave stretching
      // the clock holds the sequencer at the end of the high-going quarter.
      tick = (s_reg.tmr == 7'(`IBS_QTR_CYCLES - 1));
      go   = !(s_reg.ph == 2'h2 && !s_reg.scl_s2);
      if (s_reg.st == ibs_pkg::M_WAIT || s_reg.st == ibs_pkg::M_DONE) begin
         s_next.tmr = 7'h00;
      end else if (!tick) begin
         s_next.tmr = s_reg.tmr + 7'h01;
      end else if (go) begin
         s_next.tmr = 7'h00;
      end
      case (s_reg.st)
         ibs_pkg::M_WAIT: begin
            if (s_reg.straps_valid) begin
               if (s_reg.cap.load_inhibit) begin
                  s_next.st   = ibs_pkg::M_DONE;
                  s_next.done = 1'b1;
               end else begin
                  s_next.st   = ibs_pkg::M_START;
                  s_next.step = ibs_pkg::S_DEVW;
                  s_next.ph   = 2'h0;
                  s_next.busy = 1'b1;
               end
            end
         end
         ibs_pkg::M_START: begin
            if (tick && go) begin
               s_next.ph = s_reg.ph + 2'h1;
               case (s_reg.ph)
                  2'h0: s_next.sda_low = 1'b0;
                  2'h1: s_next.scl_low = 1'b0;
                  2'h2: s_next.sda_low = 1'b1;
                  default: begin
                     s_next.scl_low = 1'b1;
                     s_next.st      = ibs_pkg::M_TX;
                     s_next.bitn    = 4'h0;
                     s_next.sh      = {EEP_ADDR_HI, s_reg.eep_low, s_reg.step == ibs_pkg::S_DEVR};
                  end
               endcase
            end
         end
         ibs_pkg::M_TX: begin
            if (tick && go) begin
               s_next.ph = s_reg.ph + 2'h1;
               case (s_reg.ph)
                  2'h0: s_next.sda_low = (s_reg.bitn < 4'h8) ? ~s_reg.sh[7] : 1'b0;
                  2'h1: s_next.scl_low = 1'b0;
                  2'h2: s_next.nack    = (s_reg.bitn == 4'h8) ? s_reg.sda_s2 : s_reg.nack;
                  default: begin
                     s_next.scl_low = 1'b1;
                     if (s_reg.bitn < 4'h8) begin
                        s_next.sh   = {s_reg.sh[6:0], 1'b0};
                        s_next.bitn = s_reg.bitn + 4'h1;
                     end else if (s_reg.nack) begin
                        s_next.err = 1'b1;
                        s_next.st  = ibs_pkg::M_STOP;
                     end else begin
                        s_next.bitn = 4'h0;
                        case (s_reg.step)
                           ibs_pkg::S_DEVW: begin
                              s_next.step = s_reg.cap.multi_byte ? ibs_pkg::S_AHI : ibs_pkg::S_ALO;
                              s_next.sh   = s_reg.cap.multi_byte ? LOAD_ADDR[15:8] : LOAD_ADDR[7:0];
                           end
                           ibs_pkg::S_AHI: begin
                              s_next.step = ibs_pkg::S_ALO;
                              s_next.sh   = LOAD_ADDR[7:0];
                           end
                           ibs_pkg::S_ALO: begin
                              s_next.step = ibs_pkg::S_DEVR;
                              s_next.st   = ibs_pkg::M_START;
                           end
                           default: begin
                              s_next.step = ibs_pkg::S_RD;
                              s_next.st   = ibs_pkg::M_RX;
                              s_next.cnt  = 8'h00;
                           end
                        endcase
                     end
                  end
               endcase
            end
         end
         ibs_pkg::M_RX: begin
            if (tick && go) begin
               s_next.ph = s_reg.ph + 2'h1;
               case (s_reg.ph)
                  2'h0: s_next.sda_low = (s_reg.bitn == 4'h8) && (s_reg.cnt != 8'(LOAD_BYTES - 1));
                  2'h1: s_next.scl_low = 1'b0;
                  2'h2: s_next.sh      = (s_reg.bitn < 4'h8) ? {s_reg.sh[6:0], s_reg.sda_s2} : s_reg.sh;
                  default: begin
                     s_next.scl_low = 1'b1;
                     if (s_reg.bitn < 4'h8) begin
                        s_next.bitn = s_reg.bitn + 4'h1;
                        if (s_reg.bitn == 4'h7) begin
                           s_next.data  = s_reg.sh;
                           s_next.valid = 1'b1;
                        end
                     end else if (s_reg.cnt == 8'(LOAD_BYTES - 1)) begin
                        s_next.st = ibs_pkg::M_STOP;
                     end else begin
                        s_next.cnt  = s_reg.cnt + 8'h01;
                        s_next.bitn = 4'h0;
                     end
                  end
               endcase
            end
         end
         ibs_pkg::M_STOP: begin
            if (tick && go) begin
               s_next.ph = s_reg.ph + 2'h1;
               case (s_reg.ph)
                  2'h0: s_next.sda_low = 1'b1;
                  2'h1: s_next.scl_low = 1'b0;
                  2'h2: s_next.sda_low = 1'b0;
                  default: begin
                     s_next.st   = ibs_pkg::M_DONE;
                     s_next.busy = 1'b0;
                     s_next.done = 1'b1;
                  end
               endcase
            end
         end
         default: s_next.st = ibs_pkg::M_DONE;
      endcase
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   // --------------------
   // Link clock domain: pin drivers and slave
   // --------------------
   ibs_pkg::ibs_link_t l_reg;
   ibs_pkg::ibs_link_t l_next;
   logic               l_start;
   logic               l_stop;
   logic               l_rise;
   logic               l_fall;

   always_comb begin
      l_next          = l_reg;
      l_next.scl_s1   = serial_bus_clock_i;
      l_next.scl_s2   = l_reg.scl_s1;
      l_next.sda_s1   = serial_bus_data_pin_i;
      l_next.sda_s2   = l_reg.sda_s1;
      l_next.scl_d    = l_reg.scl_s2;
      l_next.sda_d    = l_reg.sda_s2;
      l_next.tog_s1   = s_reg.own_tog;
      l_next.tog_s2   = l_reg.tog_s1;
      l_next.tog_s3   = l_reg.tog_s2;
      l_next.mscl_s1  = s_reg.scl_low;
      l_next.mscl_s2  = l_reg.mscl_s1;
      l_next.msda_s1  = s_reg.sda_low;
      l_next.msda_s2  = l_reg.msda_s1;
      l_next.wr_valid = 1'b0;
      l_next.rd_load  = 1'b0;
      l_next.pin_o    = 1'b0;
      // The address bits are held steady in the system domain well before the
      // toggle arrives, so they are safe to take when it does.
      if (l_reg.tog_s2 != l_reg.tog_s3) begin
         l_next.own_low = s_reg.own_low;
         l_next.addr_ok = 1'b1;
      end
      l_start = l_reg.scl_s2 && l_reg.sda_d && !l_reg.sda_s2;
      l_stop  = l_reg.scl_s2 && !l_reg.sda_d && l_reg.sda_s2;
      l_rise  = !l_reg.scl_d && l_reg.scl_s2;
      l_fall  = l_reg.scl_d && !l_reg.scl_s2;
      if (l_start) begin
         l_next.st    = ibs_pkg::L_ADDR;
         l_next.cnt   = 4'h0;
         l_next.drive = 1'b0;
      end else if (l_stop) begin
         l_next.st    = ibs_pkg::L_IDLE;
         l_next.drive = 1'b0;
      end else if (l_rise) begin
         if (l_reg.st == ibs_pkg::L_ADDR || l_reg.st == ibs_pkg::L_WDATA) begin
            l_next.sh  = {l_reg.sh[6:0], l_reg.sda_s2};
            l_next.cnt = l_reg.cnt + 4'h1;
         end
         if (l_reg.st == ibs_pkg::L_RACK) begin
            l_next.nack = l_reg.sda_s2;
         end
      end else if (l_fall) begin
         case (l_reg.st)
            ibs_pkg::L_ADDR: begin
               if (l_reg.cnt == 4'h8) begin
                  if (l_reg.addr_ok && l_reg.sh[7:1] == {OWN_ADDR_HI, l_reg.own_low}) begin
                     l_next.drive = 1'b1;
                     l_next.rw    = l_reg.sh[0];
                     l_next.st    = ibs_pkg::L_AACK;
                  end else begin
                     l_next.st = ibs_pkg::L_IDLE;
                  end
               end
            end
            ibs_pkg::L_WDATA: begin
               if (l_reg.cnt == 4'h8) begin
                  l_next.wr_data  = l_reg.sh;
                  l_next.wr_valid = 1'b1;
                  l_next.drive    = 1'b1;
                  l_next.st       = ibs_pkg::L_WACK;
               end
            end
            ibs_pkg::L_AACK, ibs_pkg::L_WACK, ibs_pkg::L_RACK: begin
               if ((l_reg.st == ibs_pkg::L_AACK && l_reg.rw) || (l_reg.st == ibs_pkg::L_RACK && !l_reg.nack)) begin
                  l_next.sh      = slv_rd_data;
                  l_next.drive   = ~slv_rd_data[7];
                  l_next.rd_load = 1'b1;
                  l_next.cnt     = 4'h1;
                  l_next.st      = ibs_pkg::L_RDATA;
               end else begin
                  l_next.drive = 1'b0;
                  l_next.cnt   = 4'h0;
                  l_next.st    = (l_reg.st == ibs_pkg::L_RACK) ? ibs_pkg::L_IDLE : ibs_pkg::L_WDATA;
               end
            end
            ibs_pkg::L_RDATA: begin
               if (l_reg.cnt == 4'h8) begin
                  l_next.drive = 1'b0;
                  l_next.st    = ibs_pkg::L_RACK;
               end else begin
                  l_next.drive = ~l_reg.sh[6];
                  l_next.sh    = {l_reg.sh[6:0], 1'b0};
                  l_next.cnt   = l_reg.cnt + 4'h1;
               end
            end
            default: l_next.drive = 1'b0;
         endcase
      end
      // Both lines are only ever pulled low; the loader drives both, the slave only the data line.
      l_next.scl_oe = l_reg.mscl_s2;
      l_next.sda_oe = l_reg.msda_s2 | l_reg.drive;
   end

   always_ff @(posedge clk_link or posedge rst) begin
      if (rst) begin
         l_reg <= '0;
      end else begin
         l_reg <= l_next;
      end
   end

   // --------------------
   // Outputs
   // --------------------
   assign serial_bus_clock_o     = l_reg.pin_o;
   assign serial_bus_clock_oe    = l_reg.scl_oe;
   assign serial_bus_data_pin_o  = l_reg.pin_o;
   assign serial_bus_data_pin_oe = l_reg.sda_oe;
   assign slv_wr_data            = l_reg.wr_data;
   assign slv_wr_valid           = l_reg.wr_valid;
   assign slv_rd_load            = l_reg.rd_load;
   assign straps_valid           = s_reg.straps_valid;
   assign straps_captured        = s_reg.cap;
   assign own_addr_low           = s_reg.own_low;
   assign eep_addr_low           = s_reg.eep_low;
   assign load_busy              = s_reg.busy;
   assign load_done              = s_reg.done;
   assign load_error             = s_reg.err;
   assign load_data              = s_reg.data;
   assign load_valid             = s_reg.valid;

endmodule : ibs_boot_strap

`default_nettype wire

// *** ibs_boot_strap_assertions.sv ***
/*
 * Checker bound into ibs_boot_strap: strap window, address bits, serial clock rate.
 * Assumes it sees only the ports of that module.
 */
`timescale 1ns/1ps
`default_nettype none
module ibs_boot_strap_assertions (
   input wire logic                clk_sys,
   input wire logic                clk_link,
   input wire logic                rst,
   input wire logic                sw_own_wr,
   input wire logic [1:0]          sw_own_low,
   input wire logic                serial_bus_clock_oe,
   input wire logic                serial_bus_data_pin_o,
   input wire logic                straps_valid,
   input wire ibs_pkg::ibs_strap_t straps_captured,
   input wire logic [1:0]          own_addr_low,
   input wire logic [1:0]          eep_addr_low,
   input wire logic                load_done,
   input wire logic                load_error
);
   logic [3:0] win_reg;
   logic [8:0] gap_reg;
   logic       oe_reg;
   logic       seen_reg;
   wire        scl_rise = serial_bus_clock_oe & ~oe_reg;
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         win_reg  <= 4'h0;
         gap_reg  <= 9'h000;
         oe_reg   <= 1'b0;
         seen_reg <= 1'b0;
      end else begin
         oe_reg   <= serial_bus_clock_oe;
         seen_reg <= seen_reg | scl_rise;
         win_reg  <= (win_reg == 4'hF) ? win_reg : win_reg + 4'h1;
         gap_reg  <= scl_rise ? 9'h000 : (gap_reg == 9'h1FF) ? gap_reg : gap_reg + 9'h001;
      end
   end
   // Sampling the link-side enable here costs a cycle of jitter, so 248 stands for 250.
   property p_rate;
      @(posedge clk_sys) disable iff (rst) scl_rise && seen_reg |-> gap_reg >= 9'h0F8;
   endproperty
   a_rate: assert property (p_rate) else $error("serial clock too fast");
   property p_od;
      @(posedge clk_link) disable iff (rst) serial_bus_data_pin_o == 1'b0;
   endproperty
   a_od: assert property (p_od) else $error("data line driven high");
   property p_window;
      @(posedge clk_sys) disable iff (rst) straps_valid == (win_reg >= 4'hA);
   endproperty
   a_window: assert property (p_window) else $error("capture not at tenth clock");
   property p_hold;
      @(posedge clk_sys) disable iff (rst) straps_valid && $past(straps_valid) |-> $stable(straps_captured);
   endproperty
   a_hold: assert property (p_hold) else $error("captured straps changed");
   property p_own;
      @(posedge clk_sys) disable iff (rst) $rose(straps_valid) |-> own_addr_low == straps_captured.own_low;
   endproperty
   a_own: assert property (p_own) else $error("own address bits wrong");
   property p_eep;
      @(posedge clk_sys) disable iff (rst)
         $rose(straps_valid) |-> eep_addr_low == (straps_captured.eep_sel ? straps_captured.own_low : 2'h0);
   endproperty
   a_eep: assert property (p_eep) else $error("memory address bits wrong");
   property p_sw;
      @(posedge clk_sys) disable iff (rst) sw_own_wr && $past(straps_valid) |=> own_addr_low == $past(sw_own_low);
   endproperty
   a_sw: assert property (p_sw) else $error("software address not taken");
   property p_skip;
      @(posedge clk_sys) disable iff (rst)
         $rose(straps_valid) && straps_captured.load_inhibit |=> load_done && !load_error;
   endproperty
   a_skip: assert property (p_skip) else $error("inhibited load not skipped");
endmodule : ibs_boot_strap_assertions
bind ibs_boot_strap ibs_boot_strap_assertions u_chk (
   .clk_sys, .clk_link, .rst, .sw_own_wr, .sw_own_low, .serial_bus_clock_oe, .serial_bus_data_pin_o,
   .straps_valid, .straps_captured, .own_addr_low, .eep_addr_low, .load_done, .load_error
);
`default_nettype wire

// *** ibs_eeprom_model.sv ***
/*
 * Behavioural serial memory on the two-wire bus, answering one device address.
 * Assumes the bench resolves both open-drain lines with pull-ups.
 */
`timescale 1ns/1ps
`default_nettype none
module ibs_eeprom_model #(
   parameter logic [4:0] DEV_HI = 5'h14,
   parameter logic [7:0] FILL   = 8'h5A
) (
   input  wire logic       scl,
   input  wire logic       sda,
   input  wire logic [1:0] dev_low,
   output logic            sda_pull,
   output logic [7:0]      addr_bytes,
   output logic [15:0]     addr
);
   int         cnt   = 0;
   logic [7:0] sh;
   logic [7:0] dat;
   logic       sel   = 1'b0;
   logic       rd    = 1'b0;
   logic       first = 1'b1;
   initial sda_pull = 1'b0;
   // A repeated start keeps the pointer.
   always @(negedge sda) if (scl === 1'b1) begin
      cnt   = 0;
      first = 1'b1;
      rd    = 1'b0;
   end
   always @(posedge scl) begin
      if (cnt < 8) sh = {sh[6:0], sda};
      else if (rd && sda) sel = 1'b0;
      cnt = cnt + 1;
   end
   // The line is only pulled low or let go; the pull-up gives the one.
   always @(negedge scl) begin
      if (cnt == 8 && !rd) begin
         if (first) begin
            sel        = (sh[7:1] == {DEV_HI, dev_low});
            rd         = sh[0];
            addr       = sh[0] ? addr : 16'h0000;
            addr_bytes = sh[0] ? addr_bytes : 8'h00;
         end else if (sel) begin
            addr       = {addr[7:0], sh};
            addr_bytes = addr_bytes + 8'h01;
         end
         first    = 1'b0;
         sda_pull = sel;
      end else if (cnt == 8) begin
         sda_pull = 1'b0;
      end else if (cnt == 9) begin
         cnt      = 0;
         dat      = addr[7:0] ^ FILL;
         sda_pull = rd && sel && !dat[7];
         if (rd && sel) addr = addr + 16'h0001;
      end else if (rd && sel && cnt > 0) begin
         sda_pull = !dat[7 - cnt];
      end
   end
endmodule : ibs_eeprom_model
`default_nettype wire

// *** ibs_boot_strap_tb.sv ***
/*
 * Self-checking bench: strap capture, software override and boot load.
 * Assumes the memory model and the bound checker are compiled alongside.
 */
`timescale 1ns/1ps
`default_nettype none
module ibs_boot_strap_tb;
   localparam logic [15:0] LA   = 16'h0130;
   localparam int          NB   = 2;
   localparam logic [7:0]  FILL = 8'h5A;
   localparam logic [4:0]  EH   = 5'h14;
   logic                clk_sys    = 1'b0;
   logic                clk_link   = 1'b0;
   logic                rst        = 1'b1;
   ibs_pkg::ibs_strap_t straps     = '0;
   logic                sw_own_wr  = 1'b0;
   logic                sw_eep_wr  = 1'b0;
   logic [1:0]          sw_own_low = 2'h0;
   logic [1:0]          sw_eep_low = 2'h0;
   logic [1:0]          dev_low    = 2'h0;
   logic                scl_oe, sda_oe, mdl_pull, straps_valid, load_busy, load_done, load_error, load_valid;
   logic [1:0]          own_addr_low, eep_addr_low;
   logic [7:0]          load_data, mdl_nbytes;
   logic [15:0]         mdl_addr;
   logic [3:0]          w;
   ibs_pkg::ibs_strap_t straps_captured, s;
   int                  mismatches = 0;
   int                  cmp_count  = 0;
   int                  cycles     = 0;
   int                  n;
   wire                 scl_w = ~scl_oe;
   wire                 sda_w = ~(sda_oe | mdl_pull);
   always #20 clk_sys = ~clk_sys;
   initial begin
      #1.7;
      forever #3 clk_link = ~clk_link;
   end
   ibs_boot_strap #(.EEP_ADDR_HI(EH), .LOAD_ADDR(LA), .LOAD_BYTES(NB)) u_dut (
      .clk_sys, .clk_link, .rst, .straps, .sw_own_wr, .sw_own_low, .sw_eep_wr, .sw_eep_low,
      .serial_bus_clock_i(scl_w), .serial_bus_clock_o(), .serial_bus_clock_oe(scl_oe),
      .serial_bus_data_pin_i(sda_w), .serial_bus_data_pin_o(), .serial_bus_data_pin_oe(sda_oe),
      .straps_valid, .straps_captured, .own_addr_low, .eep_addr_low, .load_busy, .load_done, .load_error,
      .load_data, .load_valid, .slv_rd_data(8'h00), .slv_rd_load(),
      .slv_wr_data(), .slv_wr_valid()
   );
   ibs_eeprom_model #(.DEV_HI(EH), .FILL(FILL)) u_mem (
      .scl(scl_w), .sda(sda_w), .dev_low(dev_low), .sda_pull(mdl_pull), .addr_bytes(mdl_nbytes), .addr(mdl_addr)
   );
   function automatic logic [7:0] exp_byte(input int i);
      return (LA[7:0] + 8'(i)) ^ FILL;
   endfunction : exp_byte
   task automatic check(input logic ok, input string msg);
      cmp_count++;
      if (!ok) begin
         mismatches++;
         $display("unexpected at %0t: %s", $time, msg);
      end
   endtask : check
   task automatic final_report();
      $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : final_report
   // Straps stay put well past the window.
   task automatic do_reset(input ibs_pkg::ibs_strap_t v);
      rst    <= 1'b1;
      straps <= v;
      repeat (16) @(posedge clk_sys);
      rst <= 1'b0;
      repeat (20) @(posedge clk_sys);
      #1;
   endtask : do_reset
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 50000) begin
         mismatches++;
         $display("unexpected at %0t: timeout", $time);
         final_report();
      end
   end
   initial begin
      void'($urandom(72));
      for (int k = 0; k < 2; k++) begin
         s = 5'($urandom);
         s.load_inhibit = 1'b1;
         s.eep_sel = k[0];
         do_reset(s);
         check(straps_valid === 1'b1 && straps_captured === s, "strap capture");
         check(own_addr_low === s.own_low, "own address bits");
         check(eep_addr_low === (s.eep_sel ? s.own_low : 2'h0), "memory address bits");
         check(load_done === 1'b1 && load_busy === 1'b0 && load_error === 1'b0, "skipped load");
         @(posedge clk_sys);
         straps <= ~s;
         repeat (12) @(posedge clk_sys);
         check(straps_captured === s && own_addr_low === s.own_low, "late strap change");
         for (int j = 0; j < 3; j++) begin
            @(posedge clk_sys);
            w = 4'($urandom);
            sw_own_wr  <= 1'b1;
            sw_eep_wr  <= 1'b1;
            sw_own_low <= w[1:0];
            sw_eep_low <= w[3:2];
         end
         @(posedge clk_sys);
         sw_own_wr <= 1'b0;
         sw_eep_wr <= 1'b0;
         @(posedge clk_sys);
         #1;
         check(own_addr_low === w[1:0], "own address override");
         check(eep_addr_low === w[3:2], "memory address override");
         $display("test strap %0d done", k);
      end
      // Pass 2 addresses the wrong device, so the memory stays silent.
      for (int k = 0; k < 3; k++) begin
         s = 5'($urandom);
         s.load_inhibit = 1'b0;
         s.multi_byte = k[0];
         dev_low <= (s.eep_sel ? s.own_low : 2'h0) ^ {1'b0, k[1]};
         do_reset(s);
         n = 0;
         for (int c = 0; c < 20000 && load_done !== 1'b1; c++) begin
            @(posedge clk_sys);
            #1;
            if (load_valid === 1'b1) begin
               check(load_data === exp_byte(n), "loaded byte");
               n++;
            end
         end
         check(load_done === 1'b1 && load_error === k[1], "load end");
         check(n == (k[1] ? 0 : NB), "loaded byte count");
         if (k < 2) check(mdl_nbytes === (k[0] ? 8'h02 : 8'h01), "address byte count");
         if (k < 2) check(mdl_addr === (k[0] ? LA : {8'h00, LA[7:0]}) + 16'(NB), "load address");
         $display("test load %0d done", k);
      end
      final_report();
   end
endmodule : ibs_boot_strap_tb
`default_nettype wire
